// File: restart_policy_pkg.sv
// Purpose: constants for the fault restart policy block
// Assumes: 125 MHz reference clock
// Notes:   config register sits at its documented byte address
package restart_policy_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [7:0] CFG_ADDR       = 8'h46;
  localparam logic [7:0] CFG_RESET      = 8'h00;
  localparam int         DELAY_MSB      = 7;
  localparam int         DELAY_LSB      = 4;
  localparam int         VOLT_INH_BIT   = 3;
  localparam int         DISC_INH_BIT   = 2;
  localparam int         LOWV_INH_BIT   = 1;
  localparam int         TEMP_INH_BIT   = 0;
  localparam int         DELAY_W        = DELAY_MSB - DELAY_LSB + 1;
  localparam logic [DELAY_W-1:0] DELAY_OFF = 4'h0;

  // ****************************************************************
  // timing
  // ****************************************************************
  localparam logic [63:0] CLK_HZ        = 64'd125000000;
  localparam logic [63:0] HALF_HOUR_S   = 64'd1800;
  localparam int          STEP_W        = 40;
  localparam logic [STEP_W-1:0] HALF_HOUR_CYCLES =
    STEP_W'(HALF_HOUR_S * CLK_HZ);

  typedef enum logic {T_IDLE, T_RUN} timer_state_t;
endpackage : restart_policy_pkg

// File: restart_timer_if.sv
// Purpose: link between policy logic and restart delay timer
// Assumes: single clock domain
// Notes:   ctrl drives, tmr answers with a one-cycle expire
`timescale 1ns/1ps
`default_nettype none
interface restart_timer_if;
  logic                                  start;
  logic                                  clear;
  logic [restart_policy_pkg::DELAY_W-1:0] delay;
  logic                                  expire;
  modport ctrl (output start, output clear, output delay, input expire);
  modport tmr  (input start, input clear, input delay, output expire);
endinterface : restart_timer_if
`default_nettype wire

// File: restart_delay_timer.sv
// Purpose: half-hour step delay counter for timer-fault restart
// Assumes: clear dominates start
// Notes:   expire pulses once when the programmed delay has run out
`timescale 1ns/1ps
`default_nettype none
module restart_delay_timer #(
  parameter logic [restart_policy_pkg::STEP_W-1:0] STEP_CYCLES =
    restart_policy_pkg::HALF_HOUR_CYCLES
) (
  input  wire logic       i_ref_clk, // reference clock
  input  wire logic       i_nrst,    // sync reset, active low
  restart_timer_if.tmr    tif        // control link
);
  localparam int DW = restart_policy_pkg::DELAY_W;
  localparam int SW = restart_policy_pkg::STEP_W;

  restart_policy_pkg::timer_state_t state_r;
  logic [SW-1:0] cyc_r;
  logic [DW-1:0] half_r;
  logic [DW-1:0] target_r;
  logic          expire_r;

  // ****************************************************************
  // counter
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      state_r  <= restart_policy_pkg::T_IDLE;
      cyc_r    <= '0;
      half_r   <= '0;
      target_r <= '0;
      expire_r <= 1'b0;
    end else begin
      expire_r <= 1'b0;
      if (tif.clear) begin
        state_r <= restart_policy_pkg::T_IDLE;
        cyc_r   <= '0;
        half_r  <= '0;
      end else begin
        case (state_r)
          restart_policy_pkg::T_IDLE: begin
            if (tif.start) begin
              state_r  <= restart_policy_pkg::T_RUN;
              target_r <= tif.delay;
              cyc_r    <= '0;
              half_r   <= '0;
            end
          end
          restart_policy_pkg::T_RUN: begin
            if (cyc_r == STEP_CYCLES - SW'(1)) begin
              cyc_r <= '0;
              if (half_r + DW'(1) == target_r) begin
                expire_r <= 1'b1;
                state_r  <= restart_policy_pkg::T_IDLE;
              end else begin
                half_r <= half_r + DW'(1);
              end
            end else begin
              cyc_r <= cyc_r + SW'(1);
            end
          end
          default: state_r <= restart_policy_pkg::T_IDLE;
        endcase
      end
    end
  end

  assign tif.expire = expire_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  clear_stops_expiry_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst) tif.clear |=> !tif.expire [*2])
    else $error("expire after clear");
  expire_from_run_a: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    tif.expire |-> $past(state_r) == restart_policy_pkg::T_RUN)
    else $error("expire without running delay");
endmodule : restart_delay_timer
`default_nettype wire

// File: charger_fault_restart_policy.sv
// Purpose: restart policy after charger faults
// Assumes: fault and comparator inputs are levels from neighbour logic
// Notes:   restart and resume are one-cycle pulses to the sequencer
// Function
// - timer fault restarts at stage 0 after delay
// - zero delay field disables delayed restart
// - inhibited fault cancels pending timed restart
// - stage 2 fault, low voltage restarts
// - stage 1 fault, voltage rise restarts
// - stage 0 fault, threshold reached restarts
// - inhibit bit blocks all voltage restarts
// - inhibited disconnect stops until enable cycled
// - inhibited low voltage stops until enable cycled
// - inhibited temperature stops until enable cycled
// - inhibition evaluated for every fault independently
// - restart resets stage timers, resume does not
`timescale 1ns/1ps
`default_nettype none
module charger_fault_restart_policy #(
  parameter logic [restart_policy_pkg::STEP_W-1:0] STEP_CYCLES =
    restart_policy_pkg::HALF_HOUR_CYCLES
) (
  input  wire logic       i_ref_clk,     // reference clock
  input  wire logic       i_nrst,        // sync reset, active low
  input  wire logic [7:0] i_reg_addr,    // register address
  input  wire logic [7:0] i_reg_wdata,   // register write data
  input  wire logic       i_reg_wr,      // write strobe
  output logic      [7:0] o_reg_rdata,   // registered read data
  input  wire logic       i_charge_en,   // charge enable control level
  input  wire logic       i_s0_tfault,   // stage0 timer fault flag
  input  wire logic       i_s1_tfault,   // stage1 timer fault flag
  input  wire logic       i_s2_tfault,   // stage2 timer fault flag
  input  wire logic       i_vbat_le_s1s0,// vbat at/below s1->s0 level
  input  wire logic       i_vbat_rise5,  // vbat rose by 5 percent
  input  wire logic       i_vbat_ge_98,  // vbat at 98 percent of vs2
  input  wire logic       i_vbat_ge_s0s1,// vbat at/above s0->s1 level
  input  wire logic       i_disc_fault,  // battery disconnect fault
  input  wire logic       i_lowv_fault,  // low battery voltage fault
  input  wire logic       i_temp_fault,  // battery temperature fault
  output logic            o_restart,     // restart at stage 0 pulse
  output logic            o_timer_reset, // reset stage timers pulse
  output logic            o_resume,      // resume after temp fault
  output logic            o_locked_off,  // stopped until enable cycled
  output logic            o_charge_run   // charging permitted
);

  logic [7:0] cfg_r;
  logic [7:0] rdata_r;
  logic       locked_r;
  logic       tfault_d_r;
  logic       temp_d_r;
  logic       restart_r;
  logic       treset_r;
  logic       resume_r;
  logic       run_r;
  logic       lock_set;
  logic       tfault_any;
  logic       volt_cond;
  logic       may_restart;

  restart_timer_if tif ();

  restart_delay_timer #(.STEP_CYCLES(STEP_CYCLES)) u_delay (
    .i_ref_clk (i_ref_clk),
    .i_nrst    (i_nrst),
    .tif       (tif)
  );

  // ****************************************************************
  // register
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      cfg_r <= restart_policy_pkg::CFG_RESET;
    end else if (i_reg_wr && i_reg_addr == restart_policy_pkg::CFG_ADDR) begin
      cfg_r <= i_reg_wdata;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      rdata_r <= 8'h00;
    end else if (i_reg_addr == restart_policy_pkg::CFG_ADDR) begin
      rdata_r <= cfg_r;
    end else begin
      rdata_r <= 8'h00;
    end
  end

  // ****************************************************************
  // fault inhibition
  // ****************************************************************
  assign lock_set =
    (i_disc_fault & cfg_r[restart_policy_pkg::DISC_INH_BIT])
    | (i_lowv_fault & cfg_r[restart_policy_pkg::LOWV_INH_BIT])
    | (i_temp_fault & cfg_r[restart_policy_pkg::TEMP_INH_BIT]);

  // set wins over the enable-low clear
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      locked_r <= 1'b0;
    end else begin
      locked_r <= lock_set | (locked_r & i_charge_en);
    end
  end

  assign tfault_any  = i_s0_tfault | i_s1_tfault | i_s2_tfault;
  assign may_restart = i_charge_en & ~locked_r & ~lock_set & ~restart_r;

  assign volt_cond = ~cfg_r[restart_policy_pkg::VOLT_INH_BIT] & (
      (i_s2_tfault & i_vbat_le_s1s0)
    | (i_s1_tfault & (i_vbat_rise5 | i_vbat_ge_98))
    | (i_s0_tfault & i_vbat_ge_s0s1));

  // ****************************************************************
  // delay timer control
  // ****************************************************************
  assign tif.delay = cfg_r[restart_policy_pkg::DELAY_MSB:
                           restart_policy_pkg::DELAY_LSB];
  assign tif.start = tfault_any & ~tfault_d_r & ~locked_r & ~lock_set
                   & (tif.delay != restart_policy_pkg::DELAY_OFF);
  assign tif.clear = ~i_charge_en | locked_r | lock_set;

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      tfault_d_r <= 1'b0;
      temp_d_r   <= 1'b0;
    end else begin
      tfault_d_r <= tfault_any;
      temp_d_r   <= i_temp_fault;
    end
  end

  // ****************************************************************
  // restart and resume
  // ****************************************************************
  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      restart_r <= 1'b0;
      treset_r  <= 1'b0;
      resume_r  <= 1'b0;
    end else begin
      restart_r <= may_restart & (tif.expire | volt_cond);
      treset_r  <= may_restart & (tif.expire | volt_cond);
      resume_r  <= i_charge_en & ~locked_r & ~lock_set & temp_d_r
                 & ~i_temp_fault;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (!i_nrst) begin
      run_r <= 1'b0;
    end else begin
      run_r <= i_charge_en & ~locked_r & ~lock_set & ~tfault_any
             & ~i_temp_fault & ~i_disc_fault & ~i_lowv_fault;
    end
  end

  assign o_reg_rdata   = rdata_r;
  assign o_restart     = restart_r;
  assign o_timer_reset = treset_r;
  assign o_resume      = resume_r;
  assign o_locked_off  = locked_r;
  assign o_charge_run  = run_r;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);

  delay_restart_a: assert property (tif.expire && may_restart
    |=> o_restart && o_timer_reset)
    else $error("timed restart missing");
  zero_delay_a: assert property (tif.delay == restart_policy_pkg::DELAY_OFF
    |-> !tif.start)
    else $error("timer started with zero delay");
  lock_blocks_a: assert property (locked_r |-> tif.clear && !tif.start
    ##1 !o_restart)
    else $error("restart while locked");
  s2_volt_a: assert property (i_s2_tfault && i_vbat_le_s1s0
    && !cfg_r[restart_policy_pkg::VOLT_INH_BIT] && may_restart
    |=> o_restart)
    else $error("stage 2 voltage restart missing");
  s1_volt_a: assert property (i_s1_tfault && (i_vbat_rise5 || i_vbat_ge_98)
    && !cfg_r[restart_policy_pkg::VOLT_INH_BIT] && may_restart
    |=> o_restart)
    else $error("stage 1 voltage restart missing");
  s0_volt_a: assert property (i_s0_tfault && i_vbat_ge_s0s1
    && !cfg_r[restart_policy_pkg::VOLT_INH_BIT] && may_restart
    |=> o_restart)
    else $error("stage 0 voltage restart missing");
  volt_inhibit_a: assert property (o_restart
    && $past(cfg_r[restart_policy_pkg::VOLT_INH_BIT]) |-> $past(tif.expire))
    else $error("voltage restart while inhibited");
  lock_release_a: assert property ($fell(locked_r)
    |-> !$past(i_charge_en))
    else $error("lock released without enable off");
  lowv_lock_a: assert property (i_lowv_fault
    && cfg_r[restart_policy_pkg::LOWV_INH_BIT] |=> locked_r && !o_charge_run)
    else $error("low voltage lock missing");
  temp_lock_a: assert property (i_temp_fault
    && cfg_r[restart_policy_pkg::TEMP_INH_BIT] |=> locked_r ##1 !o_resume)
    else $error("temperature lock missing");
  any_fault_lock_a: assert property (lock_set |=> locked_r)
    else $error("inhibited fault not latched");
  resume_no_reset_a: assert property (o_resume && !o_restart
    |-> !o_timer_reset)
    else $error("timers reset on temperature resume");
  resume_pulse_a: assert property (o_resume |=> !o_resume)
    else $error("resume held longer than one cycle");
  disable_clears_a: assert property (!i_charge_en |-> tif.clear
    ##1 !tif.expire && !o_restart)
    else $error("delay not cleared when disabled");

  timed_restart_c: cover property (tif.start ##[1:1000] o_restart);
  volt_restart_c: cover property (volt_cond && may_restart ##1 o_restart);
  lock_cycle_c: cover property (locked_r ##1 !i_charge_en ##1 !locked_r);
  temp_resume_c: cover property (o_resume);
endmodule : charger_fault_restart_policy
`default_nettype wire

// File: testbench.sv
// Purpose: self-checking bench for the fault restart policy block
// Assumes: delay step shortened to STEP cycles of the reference clock
// Notes:   pulses are counted by watch, levels compared directly
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam int STEP = 10;
  logic       clk, nrst, wr, en;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] tf;   // stage 2..0 timer faults
  logic [3:0] vb;   // le_s1s0, ge_98, rise5, ge_s0s1
  logic [2:0] flt;  // disc, lowv, temp (same order as cfg bits)
  logic       rst_p, trst_p, res_p, lock, run;
  int         err_count, checked, n_rst, n_trst, n_res;
  logic [3:0] good [3];

  charger_fault_restart_policy #(
    .STEP_CYCLES(restart_policy_pkg::STEP_W'(STEP))
  ) dut_u (
    .i_ref_clk(clk), .i_nrst(nrst), .i_reg_addr(addr),
    .i_reg_wdata(wdata), .i_reg_wr(wr), .o_reg_rdata(rdata),
    .i_charge_en(en), .i_s0_tfault(tf[0]), .i_s1_tfault(tf[1]),
    .i_s2_tfault(tf[2]), .i_vbat_le_s1s0(vb[3]), .i_vbat_rise5(vb[1]),
    .i_vbat_ge_98(vb[2]), .i_vbat_ge_s0s1(vb[0]), .i_disc_fault(flt[2]),
    .i_lowv_fault(flt[1]), .i_temp_fault(flt[0]), .o_restart(rst_p),
    .o_timer_reset(trst_p), .o_resume(res_p), .o_locked_off(lock),
    .o_charge_run(run)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ****************************************************************
  // access and compare tasks
  // ****************************************************************
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_byte

  task automatic chk_bit(input logic g, input logic e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_bit

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    repeat (2) @(posedge clk);
    #1;
    chk_byte(rdata, e);
  endtask : rd_reg

  // counts pulses over n edges, sampled just after each edge
  task automatic watch(input int n);
    n_rst  = 0;
    n_trst = 0;
    n_res  = 0;
    repeat (n) begin
      @(posedge clk);
      #1;
      n_rst  += int'(rst_p === 1'b1);
      n_trst += int'(trst_p === 1'b1);
      n_res  += int'(res_p === 1'b1);
    end
  endtask : watch

  task automatic vpulse(input int st, input logic [3:0] v,
                        input logic [7:0] c, input logic e);
    wr_reg(restart_policy_pkg::CFG_ADDR, c);
    @(posedge clk);
    tf <= 3'(1 << st);
    vb <= v;
    watch(5);
    chk_bit(n_rst != 0, e);
    chk_bit(n_trst == n_rst, 1'b1);
    @(posedge clk);
    tf <= 3'h0;
    vb <= 4'h0;
    watch(3);
  endtask : vpulse

  task automatic cycle_en();
    @(posedge clk);
    en <= 1'b0;
    @(posedge clk);
    en <= 1'b1;
    watch(3);
  endtask : cycle_en

  task automatic finish_test();
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  initial begin
    #400000;
    err_count++;
    finish_test();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    int d;
    nrst = 1'b0; wr = 1'b0; en = 1'b1; addr = 8'h00; wdata = 8'h00;
    tf = 3'h0; vb = 4'h0; flt = 3'h0;
    good[0] = 4'h1; good[1] = 4'h6; good[2] = 4'h8;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    rd_reg(restart_policy_pkg::CFG_ADDR, restart_policy_pkg::CFG_RESET);
    wr_reg(8'h46, 8'ha5);
    wr_reg(8'h47, 8'h5a);
    rd_reg(8'h46, 8'ha5);
    rd_reg(8'h47, 8'h00);
    chk_bit(run, 1'b1);
    // voltage restarts, their inhibit and wrong comparators
    for (int k = 0; k < 4; k++) begin
      vpulse((k + 1) >> 1, 4'(1 << k), 8'h00, 1'b1);
      vpulse((k + 1) >> 1, 4'(1 << k), 8'h08, 1'b0);
      vpulse((k + 1) >> 1, 4'hf ^ good[(k + 1) >> 1], 8'h00, 1'b0);
    end
    // timed restart at shortest and longest delay
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 1 : 15;
      wr_reg(8'h46, 8'(d << 4));
      @(posedge clk);
      tf <= 3'(1 << k);
      watch(d * STEP - 3);
      chk_bit(n_rst == 0, 1'b1);
      watch(10);
      chk_bit(n_rst == 1 && n_trst == 1, 1'b1);
      @(posedge clk);
      tf <= 3'h0;
      watch(3);
    end
    // zero delay field
    wr_reg(8'h46, 8'h00);
    @(posedge clk);
    tf <= 3'h4;
    watch(200);
    chk_bit(n_rst == 0, 1'b1);
    @(posedge clk);
    tf <= 3'h0;
    // disable clears a pending delay
    wr_reg(8'h46, 8'h10);
    @(posedge clk);
    tf <= 3'h1;
    watch(3);
    cycle_en();
    watch(30);
    chk_bit(n_rst == 0, 1'b1);
    @(posedge clk);
    tf <= 3'h0;
    // inhibited fault cancels a pending delay
    wr_reg(8'h46, 8'h12);
    @(posedge clk);
    tf <= 3'h2;
    watch(3);
    @(posedge clk);
    flt <= 3'h2;
    @(posedge clk);
    flt <= 3'h0;
    watch(30);
    chk_bit(n_rst == 0, 1'b1);
    chk_bit(lock, 1'b1);
    @(posedge clk);
    tf <= 3'h0;
    cycle_en();
    chk_bit(lock, 1'b0);
    // each inhibit locks, with the other faults also present
    for (int b = 0; b < 3; b++) begin
      wr_reg(8'h46, 8'(1 << b));
      @(posedge clk);
      flt <= 3'h7;
      watch(3);
      chk_bit(lock, 1'b1);
      chk_bit(run, 1'b0);
      @(posedge clk);
      flt <= 3'h0;
      watch(10);
      chk_bit(lock == 1'b1 && n_rst == 0 && n_res == 0, 1'b1);
      cycle_en();
      chk_bit(lock, 1'b0);
      chk_bit(run, 1'b1);
    end
    // uninhibited temperature fault resumes without timer reset
    wr_reg(8'h46, 8'h00);
    @(posedge clk);
    flt <= 3'h1;
    watch(3);
    chk_bit(run, 1'b0);
    @(posedge clk);
    flt <= 3'h0;
    watch(4);
    chk_bit(n_res == 1 && n_trst == 0, 1'b1);
    chk_bit(run, 1'b1);
    finish_test();
  end
endmodule : testbench
`default_nettype wire
